// [rtl/adc_seq.sv]
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
// Contract
// - Oversample count 0..255 shared by all channels.
// - Each channel converts once plus oversample count.
// - Finish a channel's oversamples before advancing.
// - Oversamples run back to back, no starts.
// - Software routes ground or precision reference.
// - Factory reference value readable by host.
// - Advanced variants correct results before delivery.
// - Two counters reserved for conversion start timing.
// - Third counter's gate, clock, output on connector.
// - GP counter clock internal 10MHz or pin.
// - GP counter is sixteen bits, programmable.
// - Sample start to end channel, then wrap.
// - Enable low finishes channel before stopping.
module adc_seq (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        conv_enable_pin,
    input  wire logic        ext_trigger_pin,
    input  wire logic        ctr_clk_pin,
    input  wire logic        ctr_gate_pin,
    output var  logic        ctr_out_pin,
    output var  logic        conv_start,
    output var  logic [6:0]  conv_channel,
    output var  logic [1:0]  conv_ref_sel,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data
);
    logic [31:0] ctrl_reg;
    logic [13:0] chan_reg;
    logic [7:0]  ovs_reg;
    logic [31:0] start_div_reg;
    logic [1:0]  gp_ctrl_reg;
    logic [15:0] gp_reload_reg;
    logic [15:0] ref_value_reg;
    logic [15:0] cal_offset_reg;
    logic [15:0] cal_gain_reg;
    logic [15:0] result_reg;
    logic        result_new_reg;
    logic [31:0] div_cnt_reg;
    logic [7:0]  rep_cnt_reg;
    logic [6:0]  chan_ptr_reg;
    logic        scan_rest_reg;
    logic        start_reg;
    logic [1:0]  en_sync_reg;
    logic [2:0]  trig_sync_reg;
    logic [2:0]  cclk_sync_reg;
    logic [1:0]  gate_sync_reg;
    logic [3:0]  tick_cnt_reg;
    adc_seq_pkg::seq_state_e state_reg;
    logic [15:0] gp_count;
    logic        gp_out;

    // APB decode; zero-wait-state slave.
    wire         wr_en   = psel && penable && pwrite;
    wire         sel_any = (paddr <= `OFS_RESULT) && (paddr[1:0] == 2'b00);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !sel_any;

    wire [6:0] chan_lo  = chan_reg[6:0];
    wire [6:0] chan_hi  = chan_reg[13:7];
    wire       has_ref  = ctrl_reg[`CTRL_HAS_REF];
    wire       cal_on   = ctrl_reg[`CTRL_CAL_EN] && ctrl_reg[`CTRL_HAS_RTCAL];
    wire [1:0] src_sel  = ctrl_reg[`CTRL_SRC_HI:`CTRL_SRC_LO];
    wire       en_level = en_sync_reg[1];

    // Counters 1 and 2 are folded into one internal start divider, never shared.
    wire timer_hit = (div_cnt_reg == 32'h0000_0000);
    wire trig_edge = trig_sync_reg[1] && !trig_sync_reg[2];
    wire sw_start  = wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_SW_START];
    wire start_evt = ctrl_reg[`CTRL_ARMED] &&
                     ((src_sel == adc_seq_pkg::SRC_SOFTWARE && sw_start) ||
                      (src_sel == adc_seq_pkg::SRC_TIMER && timer_hit) ||
                      (src_sel == adc_seq_pkg::SRC_EXTERNAL && trig_edge));

    wire last_rep  = (rep_cnt_reg == ovs_reg);
    wire last_chan = (chan_ptr_reg == chan_hi);
    wire [6:0] chan_next = last_chan ? chan_lo : chan_ptr_reg + 7'h01;
    wire go_idle   = conv_done && last_rep && (!en_level || !scan_rest_reg || last_chan);

    // Offset subtract then gain multiply with saturation to 16 bits.
    function automatic logic [15:0] correct(input logic [15:0] raw,
                                            input logic [15:0] ofs,
                                            input logic [15:0] gain);
        logic [16:0] diff;
        logic [32:0] prod;
        logic [17:0] shifted;
        diff    = {1'b0, raw} - {1'b0, ofs};
        prod    = {16'h0000, diff[15:0]} * {17'h00000, gain};
        shifted = prod[`GAIN_SHIFT+17:`GAIN_SHIFT];
        if (diff[16])
            correct = 16'h0000;
        else if (shifted > 18'h0ffff)
            correct = 16'hffff;
        else
            correct = shifted[15:0];
    endfunction : correct

    wire [15:0] corrected = cal_on ? correct(conv_data, cal_offset_reg, cal_gain_reg)
                                   : conv_data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sync_reg   <= 2'b11;
            trig_sync_reg <= 3'b000;
            // The counter clock pin idles high, so no false edge follows reset.
            cclk_sync_reg <= 3'b111;
            gate_sync_reg <= 2'b11;
        end else begin
            en_sync_reg   <= {en_sync_reg[0], conv_enable_pin};
            trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_pin};
            cclk_sync_reg <= {cclk_sync_reg[1:0], ctr_clk_pin};
            gate_sync_reg <= {gate_sync_reg[0], ctr_gate_pin};
        end
    end

    // Register writes. Calibration data and the factory reference are host loaded.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg       <= 32'h0000_0000;
            chan_reg       <= 14'h0000;
            ovs_reg        <= 8'h00;
            start_div_reg  <= `START_DIV_RST;
            gp_ctrl_reg    <= 2'b00;
            gp_reload_reg  <= `GP_RELOAD_RST;
            ref_value_reg  <= `REF_RESET;
            cal_offset_reg <= 16'h0000;
            cal_gain_reg   <= `GAIN_UNITY;
        end else if (wr_en) begin
            unique case (paddr)
                `OFS_CTRL:       ctrl_reg       <= {22'h000000, pwdata[9:8], 1'b0, pwdata[6:0]};
                `OFS_CHAN:       chan_reg       <= pwdata[13:0];
                `OFS_OVS:        ovs_reg        <= pwdata[7:0];
                `OFS_START_DIV:  start_div_reg  <= pwdata;
                `OFS_GP_CTRL:    gp_ctrl_reg    <= pwdata[1:0];
                `OFS_GP_RELOAD:  gp_reload_reg  <= pwdata[15:0];
                `OFS_REF_VALUE:  ref_value_reg  <= pwdata[15:0];
                `OFS_CAL_OFFSET: cal_offset_reg <= pwdata[15:0];
                `OFS_CAL_GAIN:   cal_gain_reg   <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_cnt_reg <= `START_DIV_RST;
        else if (timer_hit)
            div_cnt_reg <= start_div_reg;
        else
            div_cnt_reg <= div_cnt_reg - 32'h0000_0001;
    end

    // Sequencer: one conversion in flight at a time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= adc_seq_pkg::SEQ_IDLE;
            rep_cnt_reg   <= 8'h00;
            chan_ptr_reg  <= 7'h00;
            scan_rest_reg <= 1'b0;
            start_reg     <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            unique case (state_reg)
                adc_seq_pkg::SEQ_IDLE: begin
                    if (!ctrl_reg[`CTRL_ARMED])
                        chan_ptr_reg <= chan_lo;
                    else if (start_evt && en_level) begin
                        state_reg     <= adc_seq_pkg::SEQ_CONVERT;
                        scan_rest_reg <= ctrl_reg[`CTRL_SCAN];
                        rep_cnt_reg   <= 8'h00;
                        start_reg     <= 1'b1;
                    end
                end
                adc_seq_pkg::SEQ_CONVERT: begin
                    if (conv_done) begin
                        if (!last_rep) begin
                            rep_cnt_reg <= rep_cnt_reg + 8'h01;
                            start_reg   <= 1'b1;
                        end else begin
                            rep_cnt_reg  <= 8'h00;
                            chan_ptr_reg <= chan_next;
                            if (go_idle)
                                state_reg <= adc_seq_pkg::SEQ_IDLE;
                            else
                                start_reg <= 1'b1;
                        end
                    end
                end
                default: state_reg <= adc_seq_pkg::SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg     <= 16'h0000;
            result_new_reg <= 1'b0;
        end else if (conv_done && state_reg == adc_seq_pkg::SEQ_CONVERT) begin
            result_reg     <= corrected;
            result_new_reg <= 1'b1;
        end else if (psel && penable && !pwrite && paddr == `OFS_RESULT)
            result_new_reg <= 1'b0;
    end

    // Internal 10MHz tick from the 100MHz clock, or external edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tick_cnt_reg <= 4'h0;
        else if (tick_cnt_reg == 4'(`TICK_DIV - 1))
            tick_cnt_reg <= 4'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end

    wire int_tick = (tick_cnt_reg == 4'(`TICK_DIV - 1));
    wire ext_tick = cclk_sync_reg[1] && !cclk_sync_reg[2];
    wire gp_tick  = gp_ctrl_reg[`GP_CTRL_EXTCLK] ? ext_tick : int_tick;
    wire gp_load  = wr_en && paddr == `OFS_GP_RELOAD;
    // A write loads the bus word; a wrap at zero reloads the stored value.
    wire [15:0] gp_reload_val = gp_load ? pwdata[15:0] : gp_reload_reg;

    gp_counter u_gp (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (gp_tick),
        .gate      (gate_sync_reg[1]),
        .run       (gp_ctrl_reg[`GP_CTRL_RUN]),
        .load      (gp_load),
        .reload    (gp_reload_val),
        .count     (gp_count),
        .out_level (gp_out)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctr_out_pin <= 1'b1;
        else
            ctr_out_pin <= gp_out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `OFS_CTRL:       prdata <= ctrl_reg;
                `OFS_CHAN:       prdata <= {18'h00000, chan_reg};
                `OFS_OVS:        prdata <= {24'h000000, ovs_reg};
                `OFS_STATUS:     prdata <= {22'h000000, result_new_reg, en_level,
                                            chan_ptr_reg, state_reg != adc_seq_pkg::SEQ_IDLE};
                `OFS_START_DIV:  prdata <= start_div_reg;
                `OFS_GP_CTRL:    prdata <= {30'h00000000, gp_ctrl_reg};
                `OFS_GP_RELOAD:  prdata <= {16'h0000, gp_reload_reg};
                `OFS_GP_COUNT:   prdata <= {16'h0000, gp_count};
                `OFS_REF_VALUE:  prdata <= {16'h0000, ref_value_reg};
                `OFS_CAL_OFFSET: prdata <= {16'h0000, cal_offset_reg};
                `OFS_CAL_GAIN:   prdata <= {16'h0000, cal_gain_reg};
                `OFS_RESULT:     prdata <= {16'h0000, result_reg};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign conv_start   = start_reg;
    assign conv_channel = chan_ptr_reg;
    // Economy variants lack the references, so the selection is forced off.
    assign conv_ref_sel = has_ref ? ctrl_reg[`CTRL_REFSEL_HI:`CTRL_REFSEL_LO] : 2'b00;

    a_ovs_count: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == adc_seq_pkg::SEQ_CONVERT |-> rep_cnt_reg <= ovs_reg)
        else $error("repeat count passed oversample setting");
    a_chan_hold: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !last_rep && state_reg == adc_seq_pkg::SEQ_CONVERT
        |=> $stable(chan_ptr_reg))
        else $error("channel advanced before oversamples finished");
    a_back_back: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !last_rep && state_reg == adc_seq_pkg::SEQ_CONVERT |=> conv_start)
        else $error("oversample not started at once");
    a_chan_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && last_rep && last_chan && state_reg == adc_seq_pkg::SEQ_CONVERT
        |=> chan_ptr_reg == $past(chan_lo))
        else $error("channel did not wrap to start");
    a_ref_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !has_ref |-> conv_ref_sel == 2'b00)
        else $error("reference routed on a board without references");
    a_en_stop: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == adc_seq_pkg::SEQ_IDLE && !en_level |=> !conv_start)
        else $error("conversion started while disabled");
    a_cal_apply: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && state_reg == adc_seq_pkg::SEQ_CONVERT
        |=> result_reg == $past(corrected))
        else $error("result not corrected");
    a_gp_step: assert property (@(posedge pclk) disable iff (!presetn)
        gp_tick && gp_ctrl_reg[`GP_CTRL_RUN] && gate_sync_reg[1] && !gp_load && gp_count != 16'h0000
        |=> gp_count == $past(gp_count) - 16'h0001)
        else $error("counter did not step");
endmodule : adc_seq
`default_nettype wire

// [rtl/adc_seq_params.svh]
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define CLK_HZ          100000000
`define TICK_HZ         10000000
`define TICK_DIV        (`CLK_HZ / `TICK_HZ)
`define OFS_CTRL        12'h000
`define OFS_CHAN        12'h004
`define OFS_OVS         12'h008
`define OFS_STATUS      12'h00c
`define OFS_START_DIV   12'h010
`define OFS_GP_CTRL     12'h014
`define OFS_GP_RELOAD   12'h018
`define OFS_GP_COUNT    12'h01c
`define OFS_REF_VALUE   12'h020
`define OFS_CAL_OFFSET  12'h024
`define OFS_CAL_GAIN    12'h028
`define OFS_RESULT      12'h02c
`define CTRL_ARMED      0
`define CTRL_SCAN       1
`define CTRL_CAL_EN     2
`define CTRL_SRC_LO     3
`define CTRL_SRC_HI     4
`define CTRL_REFSEL_LO  5
`define CTRL_REFSEL_HI  6
`define CTRL_SW_START   7
`define CTRL_HAS_REF    8
`define CTRL_HAS_RTCAL  9
`define GP_CTRL_EXTCLK  0
`define GP_CTRL_RUN     1
`define GAIN_UNITY      16'h8000
`define GAIN_SHIFT      15
`define REF_RESET       16'h0000
`define START_DIV_RST   32'h0000_00c8
`define CONV_CYCLES     8'h08
`define GP_RELOAD_RST   16'hffff
`endif

// [rtl/adc_seq_pkg.sv]
package adc_seq_pkg;
    typedef enum logic [1:0] {
        SRC_SOFTWARE,
        SRC_TIMER,
        SRC_EXTERNAL
    } start_src_e;
    typedef enum logic [1:0] {
        REF_NONE,
        REF_GROUND,
        REF_PRECISION
    } ref_sel_e;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_WAIT
    } seq_state_e;
    typedef logic [15:0] sample_t;
endpackage : adc_seq_pkg

// [rtl/gp_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
// Sixteen-bit down counter; counts a tick when its gate is high and reloads at zero.
module gp_counter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        tick,
    input  wire logic        gate,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] reload,
    output var  logic [15:0] count,
    output var  logic        out_level
);
    logic [15:0] count_reg;
    logic        out_reg;
    wire         at_zero = (count_reg == 16'h0000);
    wire         step    = run && gate && tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `GP_RELOAD_RST;
            out_reg   <= 1'b1;
        end else if (load) begin
            count_reg <= reload;
            out_reg   <= 1'b1;
        end else if (step) begin
            count_reg <= at_zero ? reload : count_reg - 16'h0001;
            out_reg   <= at_zero ? ~out_reg : out_reg;
        end
    end

    assign count     = count_reg;
    assign out_level = out_reg;
endmodule : gp_counter
`default_nettype wire

// [verif/conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Converter stand-in: one result per start, LAT cycles later.
module conv_model #(parameter int LAT = 3) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        conv_start,
    input  wire logic [15:0] sample,
    output var  logic        conv_done,
    output var  logic [15:0] conv_data
);
    logic [3:0] wait_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg  <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= 16'h0000;
        end else begin
            if (conv_start) begin
                wait_reg <= 4'(LAT);
            end else if (wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end
            conv_done <= (wait_reg == 4'h1);
            // Outside the result cycle the data lines invert every cycle, so data taken one cycle late never matches.
            conv_data <= (wait_reg == 4'h1) ? sample : ~conv_data;
        end
    end
endmodule : conv_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        en_pin, trig_pin, cclk_pin, gate_pin, cout_pin, conv_start, conv_done, rerr;
    logic [6:0]  conv_channel;
    logic [1:0]  conv_ref_sel;
    logic [15:0] conv_data, sample;
    logic [6:0]  seq_q[$];
    int          error_cnt, compares, cyc, dcyc, gap_bad, n;
    logic        pend, chk_gap;
    logic [15:0] cal_t [4][5] = '{'{16'h1100, 16'h0100, 16'h4000, 16'h0204, 16'h0800},
        '{16'hff00, 16'h0000, 16'hffff, 16'h0204, 16'hffff},
        '{16'h0050, 16'h0100, 16'h8000, 16'h0204, 16'h0000},
        '{16'h1100, 16'h0100, 16'h4000, 16'h0004, 16'h1100}};

    adc_seq i_adc_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_enable_pin(en_pin), .ext_trigger_pin(trig_pin),
        .ctr_clk_pin(cclk_pin), .ctr_gate_pin(gate_pin), .ctr_out_pin(cout_pin),
        .conv_start(conv_start), .conv_channel(conv_channel), .conv_ref_sel(conv_ref_sel),
        .conv_done(conv_done), .conv_data(conv_data));
    conv_model i_conv_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .sample(sample), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (conv_done === 1'b1) begin
            pend = chk_gap;
            dcyc = cyc;
        end
        if (conv_start === 1'b1) begin
            seq_q.push_back(conv_channel);
            if (chk_gap && pend && cyc - dcyc != 1) gap_bad++;
            pend = 1'b0;
        end
    end

    task automatic end_of_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k == 20) error_cnt++;
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wait_idle();
        int k;
        k = 0;
        repeat (3) @(posedge pclk);
        rd(`OFS_STATUS);
        while (rdata[0] !== 1'b0 && k < 1000) begin
            rd(`OFS_STATUS);
            k++;
        end
        if (k == 1000) error_cnt++;
    endtask : wait_idle

    task automatic setup(input int s, input int e, input int o);
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_CHAN, 32'(s + (e << 7)));
        wr(`OFS_OVS, 32'(o));
        seq_q.delete();
    endtask : setup

    task automatic go(input logic [31:0] c);
        wr(`OFS_CTRL, c | 32'h0000_0001);
        wr(`OFS_CTRL, c | 32'h0000_0081);
        wait_idle();
    endtask : go

    task automatic chk_seq(input int s, input int o, input int nch);
        `CHK(seq_q.size(), nch * (o + 1));
        foreach (seq_q[i]) `CHK(seq_q[i], 7'(s + i / (o + 1)));
    endtask : chk_seq

    task automatic cpulse(input int k);
        repeat (k) begin
            repeat (5) @(posedge pclk);
            cclk_pin <= 1'b1;
            repeat (5) @(posedge pclk);
            cclk_pin <= 1'b0;
        end
    endtask : cpulse

    initial begin
        #500us;
        error_cnt++;
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, trig_pin, cclk_pin, chk_gap, pend} = '0;
        {presetn, error_cnt, compares, cyc, dcyc, gap_bad} = '0;
        {en_pin, gate_pin} = 2'b11;
        sample = 16'h1234;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_START_DIV);
        `CHK(rdata, 32'h0000_00c8);
        rd(`OFS_CAL_GAIN);
        `CHK(rdata, 32'h0000_8000);
        rd(12'h030);
        `CHK({rerr, rdata}, 33'h1_0000_0000);
        wr(`OFS_REF_VALUE, 32'h0000_9f3a);
        rd(`OFS_REF_VALUE);
        `CHK(rdata, 32'h0000_9f3a);
        foreach (cal_t[i]) begin
            if (i < 3) begin
                setup(5, 5, i * 127 + (i / 2));
                go(32'h0000_0000);
                chk_seq(5, i * 127 + (i / 2), 1);
            end
        end
        setup(1, 3, 2);
        chk_gap = 1'b1;
        go(32'h0000_0002);
        chk_gap = 1'b0;
        chk_seq(1, 2, 3);
        `CHK(gap_bad, 0);
        setup(2, 3, 0);
        repeat (3) go(32'h0000_0000);
        foreach (seq_q[i]) `CHK(seq_q[i], 7'(2 + i % 2));
        setup(0, 3, 1);
        wr(`OFS_CTRL, 32'h0000_0003);
        wr(`OFS_CTRL, 32'h0000_0083);
        n = 0;
        while (conv_start !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        en_pin <= 1'b0;
        wait_idle();
        en_pin <= 1'b1;
        chk_seq(0, 1, 1);
        foreach (cal_t[i]) begin
            setup(4, 4, 0);
            wr(`OFS_CAL_OFFSET, {16'h0000, cal_t[i][1]});
            wr(`OFS_CAL_GAIN, {16'h0000, cal_t[i][2]});
            sample <= cal_t[i][0];
            go({16'h0000, cal_t[i][3]});
            rd(`OFS_STATUS);
            `CHK(rdata[9], 1'b1);
            rd(`OFS_RESULT);
            `CHK(rdata, {16'h0000, cal_t[i][4]});
            rd(`OFS_STATUS);
            `CHK(rdata[9], 1'b0);
        end
        for (int r = 0; r < 4; r++) begin
            wr(`OFS_CTRL, 32'((r % 3 + r / 3) << 5) | ((r < 3) ? 32'h0000_0100 : 32'h0000_0000));
            repeat (2) @(posedge pclk);
            `CHK(conv_ref_sel, (r < 3) ? 2'(r) : 2'b00);
        end
        setup(0, 0, 0);
        wr(`OFS_START_DIV, 32'h0000_0013);
        // Let the divider run out its old period so the new one is in force.
        repeat (210) @(posedge pclk);
        seq_q.delete();
        wr(`OFS_CTRL, 32'h0000_0009);
        repeat (200) @(posedge pclk);
        wr(`OFS_CTRL, 32'h0000_0000);
        `CHK(seq_q.size() inside {[9:11]}, 1'b1);
        setup(0, 0, 0);
        wr(`OFS_CTRL, 32'h0000_0011);
        repeat (2) begin
            trig_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            trig_pin <= 1'b0;
            repeat (20) @(posedge pclk);
        end
        `CHK(seq_q.size(), 2);
        wr(`OFS_GP_RELOAD, 32'h0000_0100);
        wr(`OFS_GP_CTRL, 32'h0000_0003);
        cpulse(3);
        rd(`OFS_GP_COUNT);
        `CHK(rdata, 32'h0000_00fd);
        gate_pin <= 1'b0;
        cpulse(2);
        rd(`OFS_GP_COUNT);
        `CHK(rdata, 32'h0000_00fd);
        gate_pin <= 1'b1;
        wr(`OFS_GP_RELOAD, 32'h0000_0003);
        cpulse(4);
        repeat (5) @(posedge pclk);
        `CHK(cout_pin, 1'b0);
        wr(`OFS_GP_CTRL, 32'h0000_0000);
        wr(`OFS_GP_RELOAD, 32'h0000_0100);
        wr(`OFS_GP_CTRL, 32'h0000_0002);
        repeat (100) @(posedge pclk);
        rd(`OFS_GP_COUNT);
        `CHK(rdata inside {[32'h0000_00f4:32'h0000_00f8]}, 1'b1);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
